// [inc/int_microframe_schedule_status_consts.vh]
// Constants for the interrupt-transfer microframe scheduling and result block.
`ifndef INT_MICROFRAME_SCHEDULE_STATUS_CONSTS_VH
`define INT_MICROFRAME_SCHEDULE_STATUS_CONSTS_VH

// ==========================================================================
// Register byte offsets on the APB.
`define OFS_WORD_TWO        8'h00
`define OFS_WORD_FOUR       8'h04
`define OFS_IRQ_STATUS      8'h08
`define OFS_IRQ_MASK        8'h0C
`define OFS_SCHED_STATE     8'h10

// ==========================================================================
// Register index codes returned by the address decoder.
`define IDX_WORD_TWO        3'h0
`define IDX_WORD_FOUR       3'h1
`define IDX_IRQ_STATUS      3'h2
`define IDX_IRQ_MASK        3'h3
`define IDX_SCHED_STATE     3'h4
`define IDX_NONE            3'h7

// ==========================================================================
// Field positions.
`define W2_ENABLE_BIT       0
`define W2_FRAME_LSB        3
`define W2_FRAME_MSB        7
`define W4_MASK_LSB         0
`define W4_MASK_MSB         7
`define W4_RESULT_LSB       8
`define W4_RESULT_MSB       31
`define RES_XACT_ERR_BIT    0
`define RES_BABBLE_BIT      1
`define RES_UNDERRUN_BIT    2
`define IRQ_DONE_BIT        0
`define IRQ_ERROR_BIT       1
`define IRQ_MISSED_BIT      2
`define SS_BUSY_BIT         0
`define SS_UFRAME_LSB       4
`define SS_UFRAME_MSB       6

// ==========================================================================
// Widths and reset values.
`define FRAME_W             5
`define UFRAME_W            3
`define NUM_UFRAMES         8
`define RESULT_W            3
`define IRQ_W               3
`define RST_FRAME           5'h00
`define RST_MASK            8'h00
`define RST_IRQ             3'h0
`define RST_RESULT          3'h0

`endif

// [hdl/uframe_result_store.v]
// Eight-entry store of per-microframe result codes, each entry register driven straight onto the read-out.
`timescale 1ns/100ps

module uframe_result_store
#(
	parameter ENTRIES = 8,
	parameter WIDTH   = 3,
	parameter AW      = 3
)
(
	input  wire                     clk,
	input  wire                     rst_n,
	input  wire                     wr_en,
	input  wire [AW-1:0]            wr_addr,
	input  wire [WIDTH-1:0]         wr_data,
	output wire [ENTRIES*WIDTH-1:0] rd_all
);

	// ======================================================================
	// Storage: one register per entry, its content forms the read data.
	genvar i;
	generate
		for (i = 0; i < ENTRIES; i = i + 1)
		begin : g_entry
			// The slot number is kept as an integer so the compare widens on purpose.
			localparam integer SLOT = i;
			reg [WIDTH-1:0] entry_r;
			always @(posedge clk or negedge rst_n)
			begin
				if (!rst_n)
					entry_r <= {WIDTH{1'b0}};
				else if (wr_en && ({{(32-AW){1'b0}}, wr_addr} == SLOT))
					entry_r <= wr_data;
			end
			assign rd_all[i*WIDTH +: WIDTH] = entry_r;
		end
	endgenerate

endmodule

// [hdl/int_microframe_schedule_status.v]
// Microframe scheduling and per-microframe result reporting for interrupt transfers.
//
// Contract
// - Eight 3-bit results, uframe7 top, uframe0 bits 10:8.
// - Hardware writes each result after transaction completes.
// - Result bits: error, babble on IN, underrun on OUT.
// - Mask consulted only when frame numbers match.
// - Issue transaction only where mask bit is one.
// - Software sets mask bits; hardware clears after processing.
// - All ones mask: transaction in all eight microframes.
// - Every fourth bit set: transaction every fourth microframe.
//
// Implementation choices: the APB slave port and the placing of the registers.
`timescale 1ns/100ps
`include "int_microframe_schedule_status_consts.vh"

module int_microframe_schedule_status
#(
	parameter AW = 8
)
(
	input  wire                  pclk,
	input  wire                  presetn,
	input  wire                  psel,
	input  wire                  penable,
	input  wire                  pwrite,
	input  wire [AW-1:0]         paddr,
	input  wire [31:0]           pwdata,
	output wire [31:0]           prdata,
	output wire                  pready,
	output wire                  pslverr,
	output wire                  irq,
	input  wire                  uframe_start,
	input  wire [`FRAME_W-1:0]   bus_frame_num,
	input  wire [`UFRAME_W-1:0]  bus_uframe,
	output wire                  txn_start,
	output wire [`UFRAME_W-1:0]  txn_uframe,
	input  wire                  txn_done,
	input  wire                  txn_is_in,
	input  wire                  txn_error,
	input  wire                  txn_babble,
	input  wire                  txn_underrun
);

	// ======================================================================
	// Scheduler states.
	localparam ST_IDLE = 1'b0;
	localparam ST_WAIT = 1'b1;

	// ======================================================================
	// Address decoding, used both for the read mux and the write strobes.
	function [2:0] reg_index;
		input [AW-1:0] addr;
		begin
			case (addr)
				`OFS_WORD_TWO:    reg_index = `IDX_WORD_TWO;
				`OFS_WORD_FOUR:   reg_index = `IDX_WORD_FOUR;
				`OFS_IRQ_STATUS:  reg_index = `IDX_IRQ_STATUS;
				`OFS_IRQ_MASK:    reg_index = `IDX_IRQ_MASK;
				`OFS_SCHED_STATE: reg_index = `IDX_SCHED_STATE;
				default:          reg_index = `IDX_NONE;
			endcase
		end
	endfunction

	// ======================================================================
	// Declarations.
	reg                   enable_r;
	reg  [`FRAME_W-1:0]   frame_sel_r;
	reg  [7:0]            mask_r;
	reg  [7:0]            mask_nxt;
	reg  [`IRQ_W-1:0]     irq_status_r;
	reg  [`IRQ_W-1:0]     irq_status_nxt;
	reg  [`IRQ_W-1:0]     irq_mask_r;
	reg  [31:0]           prdata_r;
	reg                   pready_r;
	reg                   pslverr_r;
	reg                   irq_r;
	reg                   state_r;
	reg                   state_nxt;
	reg  [`UFRAME_W-1:0]  cur_uframe_r;
	reg  [`UFRAME_W-1:0]  cur_uframe_nxt;
	reg                   txn_start_r;
	reg                   txn_start_nxt;
	reg  [`IRQ_W-1:0]     irq_event;
	reg                   res_wr_en;
	reg  [`RESULT_W-1:0]  res_wr_data;
	reg  [31:0]           read_mux;

	wire [2:0]            idx;
	wire                  setup_phase;
	wire                  wr_access;
	wire                  frame_match;
	wire                  slot_selected;
	wire [23:0]           results;

	assign idx         = reg_index(paddr);
	assign setup_phase = psel && !penable;
	assign wr_access   = psel && penable && pready_r && pwrite;

	// The mask is only looked at while the programmed frame is on the bus.
	assign frame_match   = enable_r && (bus_frame_num == frame_sel_r);
	assign slot_selected = frame_match && mask_r[bus_uframe];

	// ======================================================================
	// Result store.
	uframe_result_store
	#(
		.ENTRIES (`NUM_UFRAMES),
		.WIDTH   (`RESULT_W),
		.AW      (`UFRAME_W)
	)
	u_store
	(
		.clk     (pclk),
		.rst_n   (presetn),
		.wr_en   (res_wr_en),
		.wr_addr (cur_uframe_r),
		.wr_data (res_wr_data),
		.rd_all  (results)
	);

	// ======================================================================
	// Result encoding on completion.
	always @*
	begin
		res_wr_en   = (state_r == ST_WAIT) && txn_done;
		res_wr_data = {`RESULT_W{1'b0}};
		res_wr_data[`RES_XACT_ERR_BIT] = txn_error;
		res_wr_data[`RES_BABBLE_BIT]   = txn_babble && txn_is_in;
		res_wr_data[`RES_UNDERRUN_BIT] = txn_underrun && !txn_is_in;
	end

	// ======================================================================
	// Scheduler. In ST_IDLE each microframe start with enable set, the frame matching and its mask bit set launches one
	// transaction, so an all-ones mask serves all eight slots and a mask
	// with every fourth bit set serves every fourth slot.
	always @*
	begin
		state_nxt      = state_r;
		cur_uframe_nxt = cur_uframe_r;
		txn_start_nxt  = 1'b0;
		irq_event      = {`IRQ_W{1'b0}};
		case (state_r)
			ST_IDLE:
			begin
				if (uframe_start && slot_selected)
				begin
					state_nxt      = ST_WAIT;
					cur_uframe_nxt = bus_uframe;
					txn_start_nxt  = 1'b1;
				end
			end
			ST_WAIT:
			begin
				// A selected slot that starts while the previous transaction
				// is still open is left pending, not dropped, and reported unless txn_done is high in that cycle.
				if (uframe_start && slot_selected && !txn_done)
					irq_event[`IRQ_MISSED_BIT] = 1'b1;
				if (txn_done)
				begin
					state_nxt                 = ST_IDLE;
					irq_event[`IRQ_DONE_BIT]  = 1'b1;
					irq_event[`IRQ_ERROR_BIT] = |res_wr_data;
				end
			end
			default:
			begin
				state_nxt = ST_IDLE;
			end
		endcase
	end

	// ======================================================================
	// Mask update: software may only raise bits, hardware only lowers the
	// bit of the slot it has just finished. A software set in the same
	// cycle as the hardware clear wins, so a fresh request is kept.
	always @*
	begin
		mask_nxt = mask_r;
		if (res_wr_en)
			mask_nxt[cur_uframe_r] = 1'b0;
		if (wr_access && (idx == `IDX_WORD_FOUR))
			mask_nxt = mask_nxt | pwdata[`W4_MASK_MSB:`W4_MASK_LSB];
	end

	// ======================================================================
	// Interrupt status: write one to clear, a new event wins over the clear.
	always @*
	begin
		irq_status_nxt = irq_status_r;
		if (wr_access && (idx == `IDX_IRQ_STATUS))
			irq_status_nxt = irq_status_r & ~pwdata[`IRQ_W-1:0];
		irq_status_nxt = irq_status_nxt | irq_event;
	end

	// ======================================================================
	// Read data multiplexer.
	always @*
	begin
		read_mux = 32'h00000000;
		case (idx)
			`IDX_WORD_TWO:
			begin
				read_mux[`W2_ENABLE_BIT]                = enable_r;
				read_mux[`W2_FRAME_MSB:`W2_FRAME_LSB]  = frame_sel_r;
			end
			`IDX_WORD_FOUR:
			begin
				// Slot 7 lands in the top bits, slot 0 in bits 10 to 8.
				read_mux[`W4_RESULT_MSB:`W4_RESULT_LSB] = results;
				read_mux[`W4_MASK_MSB:`W4_MASK_LSB]     = mask_r;
			end
			`IDX_IRQ_STATUS:
				read_mux[`IRQ_W-1:0] = irq_status_r;
			`IDX_IRQ_MASK:
				read_mux[`IRQ_W-1:0] = irq_mask_r;
			`IDX_SCHED_STATE:
			begin
				read_mux[`SS_BUSY_BIT]                   = state_r;
				read_mux[`SS_UFRAME_MSB:`SS_UFRAME_LSB] = cur_uframe_r;
			end
			default:
				read_mux = 32'h00000000;
		endcase
	end

	// ======================================================================
	// APB slave. The answer is prepared during the setup cycle, so every
	// access completes at the first access-phase edge with no wait state.
	always @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			pready_r  <= 1'b0;
			pslverr_r <= 1'b0;
			prdata_r  <= 32'h00000000;
		end
		else if (setup_phase)
		begin
			pready_r  <= 1'b1;
			pslverr_r <= (idx == `IDX_NONE);
			prdata_r  <= pwrite ? 32'h00000000 : read_mux;
		end
		else
		begin
			pready_r  <= 1'b0;
			pslverr_r <= 1'b0;
		end
	end

	// ======================================================================
	// Software-controlled registers.
	always @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			enable_r    <= 1'b0;
			frame_sel_r <= `RST_FRAME;
			irq_mask_r  <= `RST_IRQ;
		end
		else if (wr_access)
		begin
			if (idx == `IDX_WORD_TWO)
			begin
				enable_r    <= pwdata[`W2_ENABLE_BIT];
				frame_sel_r <= pwdata[`W2_FRAME_MSB:`W2_FRAME_LSB];
			end
			if (idx == `IDX_IRQ_MASK)
				irq_mask_r <= pwdata[`IRQ_W-1:0];
		end
	end

	// ======================================================================
	// Scheduler, mask and interrupt state.
	always @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			state_r      <= ST_IDLE;
			cur_uframe_r <= {`UFRAME_W{1'b0}};
			txn_start_r  <= 1'b0;
			mask_r       <= `RST_MASK;
			irq_status_r <= `RST_IRQ;
			irq_r        <= 1'b0;
		end
		else
		begin
			state_r      <= state_nxt;
			cur_uframe_r <= cur_uframe_nxt;
			txn_start_r  <= txn_start_nxt;
			mask_r       <= mask_nxt;
			irq_status_r <= irq_status_nxt;
			irq_r        <= |(irq_status_nxt & irq_mask_r);
		end
	end

	// ======================================================================
	// Outputs.
	assign prdata     = prdata_r;
	assign pready     = pready_r;
	assign pslverr    = pslverr_r;
	assign irq        = irq_r;
	assign txn_start  = txn_start_r;
	assign txn_uframe = cur_uframe_r;

endmodule

// [sim/usb_device_model.sv]
// Behavioural model of the downstream device answering interrupt transactions.
`timescale 1ns/100ps

module usb_device_model
(
	input  wire       pclk,
	input  wire       presetn,
	input  wire       txn_start,
	output reg        txn_done,
	output reg        txn_is_in,
	output reg        txn_error,
	output reg        txn_babble,
	output reg        txn_underrun
);
	reg [2:0] cnt_r;
	reg       busy_r;

	// ==========================================================================
	// Answer after a random delay; flags are only meaningful with txn_done.
	always @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			busy_r   <= 1'b0;
			cnt_r    <= 3'h0;
			txn_done <= 1'b0;
			{txn_is_in, txn_error, txn_babble, txn_underrun} <= 4'h0;
		end
		else
		begin
			txn_done <= 1'b0;
			// Flags flip once released so a stale value is never mistaken for a result.
			if (txn_done)
				{txn_is_in, txn_error, txn_babble, txn_underrun} <=
					~{txn_is_in, txn_error, txn_babble, txn_underrun};
			if (txn_start)
			begin
				busy_r <= 1'b1;
				cnt_r  <= 3'($urandom % 6);
			end
			else if (busy_r && cnt_r == 3'h0)
			begin
				busy_r   <= 1'b0;
				txn_done <= 1'b1;
				{txn_is_in, txn_error, txn_babble, txn_underrun} <= 4'($urandom);
			end
			else if (busy_r)
				cnt_r <= cnt_r - 3'h1;
		end
	end
endmodule

// [sim/int_microframe_schedule_status_asserts.sv]
// Checker for the microframe scheduling block, bound to its top module.
`timescale 1ns/100ps

module sched_chk
#(
	parameter AW = 8
)
(
	input wire          pclk,
	input wire          presetn,
	input wire          psel,
	input wire          penable,
	input wire          pwrite,
	input wire [AW-1:0] paddr,
	input wire [31:0]   pwdata,
	input wire [31:0]   prdata,
	input wire          pready,
	input wire          pslverr,
	input wire          irq,
	input wire          uframe_start,
	input wire [4:0]    bus_frame_num,
	input wire [2:0]    bus_uframe,
	input wire          txn_start,
	input wire [2:0]    txn_uframe,
	input wire          txn_done,
	input wire          txn_is_in,
	input wire          txn_error,
	input wire          txn_babble,
	input wire          txn_underrun
);
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	// ==========================================================================
	// Register bus.
	a_ready_after_setup: assert property (psel && !penable |=> pready)
		else $error("pready missing after setup");
	a_ready_has_setup: assert property (pready |-> $past(psel) && !$past(penable))
		else $error("pready without setup");
	a_ready_one_cycle: assert property (pready |=> !pready)
		else $error("pready longer than one cycle");
	a_err_with_ready: assert property (pslverr |-> pready)
		else $error("pslverr without pready");
	a_err_read_zero: assert property (pslverr && !pwrite |-> prdata == 32'h0)
		else $error("refused read returned data");

	// ==========================================================================
	// Scheduling.
	a_start_after_sof: assert property (txn_start |-> $past(uframe_start))
		else $error("transaction issued outside microframe start");
	a_start_slot: assert property (txn_start |-> txn_uframe == $past(bus_uframe))
		else $error("transaction slot differs from bus microframe");
	a_start_single: assert property (txn_start |=> !txn_start)
		else $error("transaction start longer than one cycle");
	a_slot_hold: assert property (!txn_start |-> $stable(txn_uframe))
		else $error("transaction slot changed without start");
endmodule

bind int_microframe_schedule_status sched_chk #(.AW(AW)) u_chk (.pclk(pclk),
	.presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
	.pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .irq(irq),
	.uframe_start(uframe_start), .bus_frame_num(bus_frame_num), .bus_uframe(bus_uframe),
	.txn_start(txn_start), .txn_uframe(txn_uframe), .txn_done(txn_done),
	.txn_is_in(txn_is_in), .txn_error(txn_error), .txn_babble(txn_babble),
	.txn_underrun(txn_underrun));

// [sim/tb_int_microframe_schedule_status.sv]
// Self-checking testbench for the microframe scheduling block.
`timescale 1ns/100ps

`define CHK(g, e) begin checks++; if ((g) !== (e)) begin num_errors++; \
	$display("unexpected at %0t: got %h expected %h", $time, g, e); end end

module tb_int_microframe_schedule_status;
	logic        pclk, presetn, psel, penable, pwrite, uframe_start;
	logic [7:0]  paddr;
	logic [31:0] pwdata, prdata, rd;
	logic        pready, pslverr, irq, txn_start, txn_done, err;
	logic [4:0]  bus_frame_num, fr;
	logic [2:0]  bus_uframe, txn_uframe, exp_slot [8];
	logic        txn_is_in, txn_error, txn_babble, txn_underrun;
	logic [7:0]  seen, m;
	int          num_errors, checks;

	int_microframe_schedule_status uut (.pclk(pclk), .presetn(presetn), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .irq(irq), .uframe_start(uframe_start),
		.bus_frame_num(bus_frame_num), .bus_uframe(bus_uframe), .txn_start(txn_start),
		.txn_uframe(txn_uframe), .txn_done(txn_done), .txn_is_in(txn_is_in),
		.txn_error(txn_error), .txn_babble(txn_babble), .txn_underrun(txn_underrun));
	usb_device_model dev (.pclk(pclk), .presetn(presetn), .txn_start(txn_start),
		.txn_done(txn_done), .txn_is_in(txn_is_in), .txn_error(txn_error),
		.txn_babble(txn_babble), .txn_underrun(txn_underrun));

	// ==========================================================================
	// Expected result code: babble counts only on IN, underrun only on OUT.
	function automatic logic [2:0] exp_res(logic in, logic er, logic bb, logic ur);
		exp_res = {ur & ~in, bb & in, er};
	endfunction

	function automatic logic [31:0] exp_word4();
		exp_word4 = {exp_slot[7], exp_slot[6], exp_slot[5], exp_slot[4], exp_slot[3],
			exp_slot[2], exp_slot[1], exp_slot[0], 8'h00};
	endfunction

	always @(posedge pclk)
	begin
		if (txn_start)
			seen[txn_uframe] <= 1'b1;
		if (txn_done)
			exp_slot[txn_uframe] <= exp_res(txn_is_in, txn_error, txn_babble, txn_underrun);
	end

	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		psel    <= 1'b1;
		penable <= 1'b0;
		pwrite  <= w;
		paddr   <= a;
		pwdata  <= d;
		@(posedge pclk);
		penable <= 1'b1;
		// Only pready or the watchdog ends this wait; the slave's latency is not assumed.
		do
			@(posedge pclk);
		while (pready !== 1'b1);
		rd  = prdata;
		err = pslverr;
		psel    <= 1'b0;
		penable <= 1'b0;
		// One idle edge keeps a following call from driving psel twice in a step.
		@(posedge pclk);
	endtask

	// Absence of a start can only be judged by waiting out a whole slot.
	task automatic run_frame(input logic [4:0] f);
		for (int u = 0; u < 8; u++)
		begin
			uframe_start  <= 1'b1;
			bus_frame_num <= f;
			bus_uframe    <= 3'(u);
			@(posedge pclk);
			uframe_start <= 1'b0;
			repeat (12) @(posedge pclk);
		end
	endtask

	task automatic give_verdict();
		if (num_errors == 0 && checks > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask

	initial
	begin
		pclk = 1'b0;
		forever #4 pclk = ~pclk;
	end

	initial
	begin
		repeat (20000) @(posedge pclk);
		num_errors++;
		give_verdict();
	end

	initial
	begin
		{presetn, psel, penable, pwrite, uframe_start} = 5'h00;
		{paddr, pwdata, bus_frame_num, bus_uframe, seen} = '0;
		foreach (exp_slot[i]) exp_slot[i] = 3'h0;
		repeat (5) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		void'($urandom(37));
		fr = 5'($urandom % 32);
		apb(0, 8'h04, 0); `CHK(rd, 32'h0)
		apb(0, 8'h14, 0); `CHK({err, rd}, 33'h100000000)
		apb(1, 8'h00, {24'h0, fr, 3'h1});
		apb(1, 8'h0C, 32'h7);
		apb(1, 8'h04, 32'h1);
		apb(1, 8'h04, 32'hFFFFFF10);
		apb(0, 8'h04, 0); `CHK(rd, 32'h11)
		apb(0, 8'h00, 0); `CHK(rd, {24'h0, fr, 3'h1})
		run_frame(fr + 5'h1);
		`CHK(seen, 8'h00)
		for (int i = 0; i < 5; i++)
		begin
			m = (i == 0) ? 8'h11 : (i == 1) ? 8'hFF : 8'($urandom);
			if (i > 0)
				apb(1, 8'h04, {24'h0, m});
			seen = 8'h00;
			run_frame(fr);
			`CHK(seen, m)
			apb(0, 8'h04, 0); `CHK(rd, exp_word4())
		end
		apb(0, 8'h08, 0); `CHK(rd[0], 1'b1)
		`CHK(irq, 1'b1)
		apb(1, 8'h08, 32'h7);
		repeat (2) @(posedge pclk);
		`CHK(irq, 1'b0)
		// A selected slot that starts while the previous one is open stays pending.
		apb(1, 8'h04, 32'h3);
		uframe_start  <= 1'b1;
		bus_frame_num <= fr;
		bus_uframe    <= 3'h0;
		@(posedge pclk);
		bus_uframe <= 3'h1;
		@(posedge pclk);
		uframe_start <= 1'b0;
		repeat (12) @(posedge pclk);
		apb(0, 8'h08, 0); `CHK(rd[2], 1'b1)
		apb(0, 8'h04, 0); `CHK(rd[7:0], 8'h02)
		give_verdict();
	end
endmodule
